// ==== common/ppm_pkg.sv ====
// ppm_pkg: constants for the parallel port pin multiplexer.
// assumes: included before the design modules that import it.
package ppm_pkg;

    // ------------------------------------------------------------
    // parallel-port mode field
    // ------------------------------------------------------------
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_MEM_A = 2'h0;
    localparam logic [1:0] MODE_MEM_B = 2'h1;
    localparam logic [1:0] MODE_GPIO = 2'h2;
    localparam logic [1:0] MODE_HOST = 2'h3;
    // reset loads of the mode field from the boot configuration pin
    localparam logic [1:0] MODE_RST_BOOT_HI = 2'h1;
    localparam logic [1:0] MODE_RST_BOOT_LO = 2'h3;

    // ------------------------------------------------------------
    // host-port register selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PPM_HREG_CTRL,
        PPM_HREG_DATA_AUTO,
        PPM_HREG_ADDR,
        PPM_HREG_DATA
    } ppm_hreg_t;

    localparam int SYNC_STAGES = 2;

endpackage

// ==== verilog/ppm_sync.sv ====
// ppm_sync: two-flop synchroniser for a bus of pin inputs.
// assumes: inputs are asynchronous to clock; only the second stage is read.
// the stages are not reset so a strap level passes while reset is held.
`timescale 1ns/1ps
module ppm_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input wire logic clock,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;

endmodule

// ==== verilog/ppm_pin_mux.sv ====
// ppm_pin_mux: routes four shared parallel-port pins between memory
// chip selects, general-purpose lines and host-port control inputs.
// assumes: one clock; pin levels and boot pin come from outside and are
// synchronised here; memory selects and gpio drives come from same-clock
// logic; the testbench resolves the pin wires from the enables.
`timescale 1ns/1ps

// Contract
// - modes 00/01: space0 select on pin a
// - modes 10/11: pin a is general line 9
// - modes 00/01: space1 select on pin b
// - modes 10/11: pin b is general line 10
// - modes 00/01: space2 select on pin c
// - modes 10/11: pin c is host bit0 input
// - modes 00/01: space3 select on pin d
// - mode 10 only: pin d general line 11
// - mode 11: pin d is host bit1 input
// - host bits decode to host register
// - memory selects active low, high idle
// - boot pin picks reset pin function
module ppm_pin_mux
    import ppm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // boot configuration pin
    input wire logic boot_config_pin,
    // mode field write from the bus selection logic
    input wire logic mode_wr,
    input wire logic [MODE_W-1:0] mode_wdata,
    output logic [MODE_W-1:0] mode_q_out,
    // memory interface chip selects, active low
    input wire logic mem_select_space0_n,
    input wire logic mem_select_space1_n,
    input wire logic mem_select_space2_n,
    input wire logic mem_select_space3_n,
    // general-purpose lines 9..11: drive value and direction
    input wire logic [2:0] general_line_out,
    input wire logic [2:0] general_line_dir,
    output logic [2:0] general_line_in,
    // host-port control
    output logic host_ctrl_bit0,
    output logic host_ctrl_bit1,
    output ppm_hreg_t host_reg_sel,
    output logic host_ctrl_valid,
    // shared pins a..d
    input wire logic [3:0] shared_pin_i,
    output logic [3:0] shared_pin_o,
    output logic [3:0] shared_pin_oe
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync_s;

    // free running, so the strap is settled on the first edge after reset
    ppm_sync #(
        .WIDTH(5)
    ) u_sync (
        .clock(clock),
        .async_in({boot_config_pin, shared_pin_i}),
        .sync_out(sync_s)
    );

    logic boot_s;
    logic [3:0] pin_s;
    assign boot_s = sync_s[4];
    assign pin_s = sync_s[3:0];

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] mode_d;
    logic rst_seen_q;
    logic rst_seen_d;

    always_comb begin
        mode_d = mode_q;
        rst_seen_d = 1'b1;
        if (!rst_seen_q) begin
            mode_d = boot_s ? MODE_RST_BOOT_HI : MODE_RST_BOOT_LO;
        end else if (mode_wr) begin
            // a write on the strap-load edge is ignored
            mode_d = mode_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_q <= MODE_RST_BOOT_LO;
            rst_seen_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            rst_seen_q <= rst_seen_d;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // strap_done is low on the strap-load edge; pins stay quiet then so a
    // gpio direction cannot drive a pin the strap makes a memory select
    logic strap_done;
    logic mem_mode;
    logic gpio_d_mode;
    assign strap_done = rst_seen_q;
    assign mem_mode = (mode_q == MODE_MEM_A) || (mode_q == MODE_MEM_B);
    assign gpio_d_mode = (mode_q == MODE_GPIO);

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------

    logic [3:0] pin_o_q;
    logic [3:0] pin_o_d;
    logic [3:0] pin_oe_q;
    logic [3:0] pin_oe_d;
    logic [2:0] gin_q;
    logic [2:0] gin_d;
    logic hb0_q;
    logic hb0_d;
    logic hb1_q;
    logic hb1_d;
    ppm_hreg_t hsel_q;
    ppm_hreg_t hsel_d;
    logic hval_q;
    logic hval_d;

    always_comb begin
        pin_o_d = 4'hf;
        pin_oe_d = 4'h0;
        gin_d = 3'h0;
        hb0_d = 1'b0;
        hb1_d = 1'b0;
        hval_d = 1'b0;
        if (!strap_done) begin
            pin_oe_d = 4'h0;
        end else if (mem_mode) begin
            pin_o_d[0] = mem_select_space0_n;
            pin_o_d[1] = mem_select_space1_n;
            pin_o_d[2] = mem_select_space2_n;
            pin_o_d[3] = mem_select_space3_n;
            pin_oe_d = 4'hf;
        end else begin
            pin_o_d[0] = general_line_out[0];
            pin_oe_d[0] = general_line_dir[0];
            gin_d[0] = pin_s[0];
            pin_o_d[1] = general_line_out[1];
            pin_oe_d[1] = general_line_dir[1];
            gin_d[1] = pin_s[1];
            hb0_d = pin_s[2];
            if (gpio_d_mode) begin
                pin_o_d[3] = general_line_out[2];
                pin_oe_d[3] = general_line_dir[2];
                gin_d[2] = pin_s[3];
            end else begin
                hb1_d = pin_s[3];
                hval_d = 1'b1;
            end
        end
        // decode host register
        // in mode 10 the upper host bit reads as zero
        hsel_d = ppm_hreg_t'({hb1_d, hb0_d});
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_o_q <= 4'hf;
            pin_oe_q <= 4'h0;
            gin_q <= 3'h0;
            hb0_q <= 1'b0;
            hb1_q <= 1'b0;
            hsel_q <= PPM_HREG_CTRL;
            hval_q <= 1'b0;
        end else begin
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            gin_q <= gin_d;
            hb0_q <= hb0_d;
            hb1_q <= hb1_d;
            hsel_q <= hsel_d;
            hval_q <= hval_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign shared_pin_o = pin_o_q;
    assign shared_pin_oe = pin_oe_q;
    assign general_line_in = gin_q;
    assign host_ctrl_bit0 = hb0_q;
    assign host_ctrl_bit1 = hb1_q;
    assign host_reg_sel = hsel_q;
    assign host_ctrl_valid = hval_q;
    assign mode_q_out = mode_q;

endmodule

// ==== tb/ppm_far.sv ====
// ppm_far: memories or host on the far side of the shared pins
// assumes: the bench sets the levels the far side drives
`timescale 1ns/1ps
module ppm_far (
    input wire logic [3:0] o,
    input wire logic [3:0] oe,
    input wire logic [3:0] lvl,
    output logic [3:0] pin
);
    // host drives both control bits as one pair
    assign pin = (oe & o) | (~oe & lvl);
endmodule

// ==== tb/ppm_pin_mux_sva.sv ====
// ppm_pin_mux_sva: port checks for the pin mux
// assumes: bound to ppm_pin_mux, one clock
`timescale 1ns/1ps
module ppm_pin_mux_sva
    import ppm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic boot_config_pin,
    input wire logic mode_wr,
    input wire logic [MODE_W-1:0] mode_wdata,
    input wire logic [MODE_W-1:0] mode_q_out,
    input wire logic mem_select_space0_n,
    input wire logic mem_select_space1_n,
    input wire logic mem_select_space2_n,
    input wire logic mem_select_space3_n,
    input wire logic [2:0] general_line_dir,
    input wire logic host_ctrl_bit0,
    input wire logic host_ctrl_bit1,
    input wire ppm_hreg_t host_reg_sel,
    input wire logic [3:0] shared_pin_o,
    input wire logic [3:0] shared_pin_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wr;
        mode_wr && $past(rst_n);
    endsequence
    a_reset_quiet:
        assert property (disable iff (1'b0) !rst_n |=>
        shared_pin_oe == 4'h0) else $error("oe in reset");
    a_strap_load:
        assert property ($rose(rst_n) |=> mode_q_out ==
        (boot_config_pin ? MODE_RST_BOOT_HI : MODE_RST_BOOT_LO))
        else $error("strap load");
    a_mode_write:
        assert property (s_wr |=> mode_q_out == $past(mode_wdata))
        else $error("mode write");
    a_mem_pins:
        assert property ($past(rst_n, 2) && $past(rst_n) &&
        !$past(mode_q_out[1]) |->
        shared_pin_oe == 4'hf && shared_pin_o == $past({
        mem_select_space3_n, mem_select_space2_n,
        mem_select_space1_n, mem_select_space0_n})) else $error("mem");
    a_gpio_ab:
        assert property ($past(rst_n, 2) && $past(rst_n) &&
        $past(mode_q_out[1]) |->
        shared_pin_oe[1:0] == $past(general_line_dir[1:0]))
        else $error("gpio a b");
    a_pin_d_gpio:
        assert property ($past(rst_n, 2) && $past(rst_n) &&
        $past(mode_q_out) == MODE_GPIO
        |-> shared_pin_oe[3:2] == {$past(general_line_dir[2]), 1'b0})
        else $error("pin d gpio");
    a_pin_d_host:
        assert property ($past(rst_n, 2) && $past(rst_n) &&
        $past(mode_q_out) == MODE_HOST
        |-> shared_pin_oe[3:2] == 2'h0) else $error("pin c d host");
    a_host_decode:
        assert property (mode_q_out == MODE_HOST && $stable(mode_q_out)
        |-> host_reg_sel == {host_ctrl_bit1, host_ctrl_bit0})
        else $error("host decode");
endmodule
bind ppm_pin_mux ppm_pin_mux_sva i_ppm_pin_mux_sva (.clock, .rst_n,
    .boot_config_pin, .mode_wr, .mode_wdata, .mode_q_out,
    .mem_select_space0_n, .mem_select_space1_n, .mem_select_space2_n,
    .mem_select_space3_n, .general_line_dir, .host_ctrl_bit0,
    .host_ctrl_bit1, .host_reg_sel, .shared_pin_o, .shared_pin_oe);

// ==== tb/parallel_port_pin_mux_test.sv ====
// parallel_port_pin_mux_test: scenario bench for the pin mux
// assumes: package, design, far side and checker compiled first
`timescale 1ns/1ps
module parallel_port_pin_mux_test
    import ppm_pkg::*;
;
    logic clock = 1'h0, rst_n = 1'h0, boot = 1'h1, wr = 1'h0;
    logic [1:0] wd = 2'h0, mode;
    logic [3:0] sel = 4'hf, far = 4'h0, pi, po, oe;
    logic [2:0] go = 3'h0, gd = 3'h0, gi;
    logic hb0, hb1, hv;
    ppm_hreg_t hs;
    int n_fail = 0, check_count = 0, cyc = 0;
    always #2 clock = ~clock;
    ppm_pin_mux i_ppm_pin_mux (.clock, .rst_n, .boot_config_pin(boot),
        .mode_wr(wr), .mode_wdata(wd), .mode_q_out(mode),
        .mem_select_space0_n(sel[0]), .mem_select_space1_n(sel[1]),
        .mem_select_space2_n(sel[2]), .mem_select_space3_n(sel[3]),
        .general_line_out(go), .general_line_dir(gd), .general_line_in(gi),
        .host_ctrl_bit0(hb0), .host_ctrl_bit1(hb1), .host_reg_sel(hs),
        .host_ctrl_valid(hv), .shared_pin_i(pi), .shared_pin_o(po),
        .shared_pin_oe(oe));
    ppm_far i_ppm_far (.o(po), .oe(oe), .lvl(far), .pin(pi));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_reset(input logic b);
        boot = b;
        rst_n = 1'h0;
        step(2);
        rst_n = 1'h1;
        step(1);
        chk(oe, 4'h0);
        chk({2'h0, mode}, b ? 4'h1 : 4'h3);
        step(1);
        chk(oe, b ? 4'hf : {2'h0, gd[1:0]});
    endtask
    task automatic set_mode(input logic [1:0] m);
        wr = 1'h1;
        wd = m;
        step(1);
        wr = 1'h0;
        chk({2'h0, mode}, {2'h0, m});
        step(1);
    endtask
    task automatic t_mem(input logic [1:0] m);
        set_mode(m);
        for (int k = 0; k < 5; k++) begin
            sel = ~(4'h1 << k);
            step(1);
            chk(oe, 4'hf);
            chk(po, sel);
        end
    endtask
    task automatic t_gpio();
        set_mode(MODE_GPIO);
        gd = 3'h7;
        go = 3'h5;
        step(1);
        chk(oe, 4'hb);
        chk(po, 4'hd);
        gd = 3'h0;
        far = 4'h6;
        step(4);
        chk({1'h0, gi}, 4'h2);
        chk({2'h0, hs}, 4'h1);
    endtask
    task automatic t_host();
        set_mode(MODE_HOST);
        gd = 3'h7;
        for (int k = 0; k < 4; k++) begin
            far = {k[1:0], 2'h0};
            step(4);
            chk(oe, 4'h3);
            chk({hv, hb1, hb0, gi[2]}, {1'h1, k[1:0], 1'h0});
            chk({2'h0, hs}, {2'h0, k[1:0]});
        end
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 500) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        t_reset(1'h1);
        t_mem(MODE_MEM_A);
        t_mem(MODE_MEM_B);
        t_gpio();
        t_host();
        t_reset(1'h0);
        tally_and_finish();
    end
endmodule
